//--- hdl/isr_pkg.sv
// Behaviour
// - Select clock source when power-on reset ends
// - Pull-up during reset; high pin selects internal
// - Clock and output high while converting
// - Clock and output low at conversion done
// - Sleep half clock period, then transfer
// - Sample input on every rising edge
// - Change output on every falling edge
// - After 32nd rise, start new conversion
// - Pull-up off whenever clock pin low, except in reset or while a sleep probe sees chip select high
// - Chip select rise with clock low, then a fall in sleep, exits mode
// - Short chip-select pulse in sleep re-enables pull-up
// - Received word applies to next conversion
// - First rise follows a chip-select fall in sleep by the probe delay plus one clock period
package isr_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned POR_US = 4000;
  localparam int unsigned POR_CYC = POR_US * (CLK_HZ / 1_000_000);
  localparam int unsigned PROBE_US = 12;
  localparam int unsigned PROBE_CYC = PROBE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned HALF_SCK_CYC = 16;
  localparam int unsigned CONV_CYC = 1000;
  localparam int unsigned FRAME_BITS = 32;
  localparam int unsigned RES_BITS = 31;
  localparam int unsigned CFG_BITS = 16;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned BIT_W = 6;
endpackage

//--- hdl/isr_buf_if.sv
`timescale 1ns/1ps
`default_nettype none
interface isr_buf_if;
  logic in_valid;
  logic in_ready;
  logic [30:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [30:0] out_data;
  modport src (output in_valid, output in_data, input in_ready, input out_valid, input out_data, output out_ready);
  modport buf_side (input in_valid, input in_data, output in_ready, output out_valid, output out_data, input out_ready);
endinterface
`default_nettype wire

//--- hdl/isr_buf.sv
`timescale 1ns/1ps
`default_nettype none
module isr_buf
  import isr_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Stream
  isr_buf_if.buf_side bus
);
  logic [30:0] mem_r [2];
  logic wr_r;
  logic rd_r;
  logic [1:0] cnt_r;
  logic push;
  logic pop;
  assign bus.in_ready = (cnt_r != 2'h2);
  assign bus.out_valid = (cnt_r != 2'h0);
  assign bus.out_data = mem_r[rd_r];
  assign push = bus.in_valid && bus.in_ready;
  assign pop = bus.out_valid && bus.out_ready;
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_r[wr_r] <= bus.in_data;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) begin
        wr_r <= ~wr_r;
      end
      if (pop) begin
        rd_r <= ~rd_r;
      end
      cnt_r <= 2'(cnt_r + {1'b0, push} - {1'b0, pop});
    end
  end
  property p_no_over;
    @(posedge ref_clk) disable iff (!resetn) (cnt_r == 2'h2 && !pop) |=> cnt_r == 2'h2;
  endproperty
  a_no_over: assert property (p_no_over) else $error("buffer lost a word");
endmodule
`default_nettype wire

//--- hdl/isr_readout.sv
`timescale 1ns/1ps
`default_nettype none
module isr_readout
  import isr_pkg::*;
#(
  parameter int unsigned POR_CYCLES = POR_CYC,
  parameter int unsigned PROBE_CYCLES = PROBE_CYC,
  parameter int unsigned CONV_CYCLES = CONV_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Serial pins
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  output logic sck_pullup_en,
  input wire logic cs_n_in,
  input wire logic sdi_in,
  output logic sdo_out,
  // Converter side
  input wire logic [30:0] result_data,
  input wire logic result_valid,
  output logic result_ready,
  output logic [15:0] cfg_word,
  output logic cfg_valid,
  output logic internal_mode,
  output logic converting
);
  typedef enum logic [4:0] {
    ST_POR = 5'h01, ST_CONV = 5'h02, ST_SLEEP = 5'h04, ST_XFER = 5'h08, ST_EXT = 5'h10
  } isr_state_t;
  isr_state_t st_r;
  logic [CNT_W-1:0] cnt_r;
  logic [BIT_W-1:0] bit_r;
  logic phase_r;
  logic [31:0] sh_r;
  logic [15:0] in_r;
  logic [15:0] pend_r;
  logic pend_v_r;
  logic [1:0] sck_s_r;
  logic [1:0] cs_s_r;
  logic [1:0] sdi_s_r;
  logic cs_d_r;
  logic stuck_r;
  logic probe_r;
  logic [CNT_W-1:0] probe_cnt_r;
  logic half_tick;
  isr_buf_if bif ();
  isr_buf u_buf (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .bus(bif.buf_side)
  );
  assign bif.in_valid = result_valid;
  assign bif.in_data = result_data;
  assign result_ready = bif.in_ready;
  assign bif.out_ready = (st_r == ST_CONV) && (cnt_r >= CNT_W'(CONV_CYCLES));
  assign half_tick = (cnt_r == CNT_W'(HALF_SCK_CYC - 1));
  assign internal_mode = (st_r != ST_POR) && (st_r != ST_EXT);
  assign converting = (st_r == ST_CONV);
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sck_s_r <= 2'h3;
      cs_s_r <= 2'h3;
      sdi_s_r <= 2'h0;
      cs_d_r <= 1'b1;
    end else begin
      sck_s_r <= {sck_s_r[0], sck_in};
      cs_s_r <= {cs_s_r[0], cs_n_in};
      sdi_s_r <= {sdi_s_r[0], sdi_in};
      cs_d_r <= cs_s_r[1];
    end
  end
  // Pull-up on during reset and while a probe sees chip select high, else off while pin reads low
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sck_pullup_en <= 1'b1;
    end else if (st_r == ST_POR) begin
      sck_pullup_en <= 1'b1;
    end else if (probe_r && cs_s_r[1]) begin
      sck_pullup_en <= 1'b1;
    end else if (!sck_s_r[1]) begin
      sck_pullup_en <= 1'b0;
    end else begin
      sck_pullup_en <= 1'b1;
    end
  end
  // Chip select rise while clock held low leaves pin low
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      stuck_r <= 1'b0;
    end else if (cs_s_r[1] && !cs_d_r && !sck_out) begin
      stuck_r <= 1'b1;
    end else if (!cs_s_r[1] && sck_s_r[1]) begin
      stuck_r <= 1'b0;
    end
  end
  // Status probe in sleep
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      probe_r <= 1'b0;
      probe_cnt_r <= '0;
    end else if (st_r == ST_SLEEP && !cs_s_r[1] && cs_d_r) begin
      probe_r <= 1'b1;
      probe_cnt_r <= '0;
    end else if (probe_r) begin
      probe_cnt_r <= CNT_W'(probe_cnt_r + 1'b1);
      if (cs_s_r[1] || probe_cnt_r >= CNT_W'(PROBE_CYCLES - 1)) begin
        probe_r <= 1'b0;
      end
    end
  end
  // Main sequencer
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_r <= ST_POR;
      cnt_r <= '0;
      bit_r <= '0;
      phase_r <= 1'b0;
      sh_r <= '1;
      in_r <= '0;
      sck_out <= 1'b1;
      sck_oe <= 1'b0;
      sdo_out <= 1'b1;
    end else begin
      unique case (st_r)
        ST_POR: begin
          cnt_r <= CNT_W'(cnt_r + 1'b1);
          if (cnt_r >= CNT_W'(POR_CYCLES - 1)) begin
            cnt_r <= '0;
            st_r <= sck_s_r[1] ? ST_CONV : ST_EXT;
            sck_oe <= sck_s_r[1];
          end
        end
        ST_CONV: begin
          sck_out <= 1'b1;
          sdo_out <= 1'b1;
          if (cnt_r < CNT_W'(CONV_CYCLES)) begin
            cnt_r <= CNT_W'(cnt_r + 1'b1);
          end else if (bif.out_valid) begin
            sh_r <= {1'b0, bif.out_data};
            sck_out <= 1'b0;
            sdo_out <= 1'b0;
            cnt_r <= '0;
            st_r <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          cnt_r <= CNT_W'(cnt_r + 1'b1);
          if (stuck_r && !cs_s_r[1] && cs_d_r) begin
            st_r <= ST_EXT;
            sck_oe <= 1'b0;
          end else if (probe_r) begin
            // Sleep timing restarts once the probe has ended
            cnt_r <= '0;
          end else if (half_tick) begin
            cnt_r <= '0;
            bit_r <= '0;
            phase_r <= 1'b0;
            sh_r <= {sh_r[30:0], 1'b1};
            st_r <= ST_XFER;
          end
        end
        ST_XFER: begin
          cnt_r <= CNT_W'(cnt_r + 1'b1);
          if (half_tick) begin
            cnt_r <= '0;
            phase_r <= ~phase_r;
            if (!phase_r) begin
              sck_out <= 1'b1;
              in_r <= {in_r[14:0], sdi_s_r[1]};
              bit_r <= BIT_W'(bit_r + 1'b1);
              if (bit_r == BIT_W'(FRAME_BITS - 1)) begin
                // Last bit holds past the 32nd rise; the conversion state raises it
                st_r <= ST_CONV;
              end
            end else begin
              sck_out <= 1'b0;
              sdo_out <= sh_r[31];
              sh_r <= {sh_r[30:0], 1'b1};
            end
          end
        end
        ST_EXT: begin
          sck_oe <= 1'b0;
        end
        default: st_r <= ST_POR;
      endcase
    end
  end
  // Word latched at the 16th rise, applied at the 32nd, used only from the next conversion
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pend_r <= '0;
      pend_v_r <= 1'b0;
      cfg_word <= '0;
      cfg_valid <= 1'b0;
    end else begin
      cfg_valid <= 1'b0;
      if (st_r == ST_XFER && half_tick && !phase_r && bit_r == BIT_W'(CFG_BITS - 1)) begin
        pend_r <= {in_r[14:0], sdi_s_r[1]};
        pend_v_r <= 1'b1;
      end
      if (st_r == ST_XFER && half_tick && !phase_r && bit_r == BIT_W'(FRAME_BITS - 1) && pend_v_r) begin
        cfg_word <= pend_r;
        cfg_valid <= 1'b1;
        pend_v_r <= 1'b0;
      end
    end
  end
  property p_conv_high;
    @(posedge ref_clk) disable iff (!resetn) $rose(converting) |-> ##1 (sck_out && sdo_out)[*4];
  endproperty
  a_conv_high: assert property (p_conv_high) else $error("clock or data low in conversion");
  property p_done_low;
    @(posedge ref_clk) disable iff (!resetn) (st_r == ST_CONV) ##1 (st_r == ST_SLEEP) |-> !sck_out && !sdo_out;
  endproperty
  a_done_low: assert property (p_done_low) else $error("done not signalled low");
  property p_sleep_len;
    @(posedge ref_clk) disable iff (!resetn) $rose(st_r == ST_SLEEP) |-> (st_r == ST_SLEEP)[*8] ##1 (st_r == ST_SLEEP)[*8];
  endproperty
  a_sleep_len: assert property (p_sleep_len) else $error("sleep too short");
  property p_end_frame;
    @(posedge ref_clk) disable iff (!resetn) (st_r == ST_XFER && bit_r == 6'h1F && half_tick && !phase_r) |=> converting;
  endproperty
  a_end_frame: assert property (p_end_frame) else $error("no conversion after 32nd rise");
  property p_pullup_off;
    @(posedge ref_clk) disable iff (!resetn) (!sck_s_r[1] && st_r != ST_POR && !probe_r && !cs_s_r[1]) |=> !sck_pullup_en;
  endproperty
  a_pullup_off: assert property (p_pullup_off) else $error("pull-up on with clock low");
  property p_por_pull;
    @(posedge ref_clk) disable iff (!resetn) (st_r == ST_POR) |=> sck_pullup_en;
  endproperty
  a_por_pull: assert property (p_por_pull) else $error("pull-up off during power-on");
  property p_sdo_fall;
    @(posedge ref_clk) disable iff (!resetn) (st_r == ST_XFER && $changed(sdo_out)) |-> $fell(sck_out);
  endproperty
  a_sdo_fall: assert property (p_sdo_fall) else $error("output changed off falling edge");
  property p_cfg_once;
    @(posedge ref_clk) disable iff (!resetn) cfg_valid |=> converting && !cfg_valid;
  endproperty
  a_cfg_once: assert property (p_cfg_once) else $error("word applied outside boundary");
endmodule
`default_nettype wire

//--- dv/isr_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module isr_ctrl_model (
  // Link pins
  input wire logic sck,
  input wire logic sdo,
  output logic cs_n,
  output logic sdi,
  // Chip select request, word to send and frame seen
  input wire logic cs_lift,
  input wire logic [15:0] cfg,
  output logic [31:0] frame,
  output logic [31:0] nbits
);
  logic [4:0] idx;
  assign idx = nbits[4:0];
  // Chip select stays low unless the bench lifts it for the probe scenario
  assign cs_n = cs_lift;
  initial begin
    sdi = 1'b1;
    frame = '0;
    nbits = '0;
  end
  // Inputs move only on falling clock, so they stay static while converting
  always @(negedge sck) begin
    sdi <= (idx < 5'h10) ? cfg[4'hF - idx[3:0]] : idx[0];
  end
  // Done bit lands on the first rise, last result bit on the 32nd
  always @(posedge sck) begin
    frame <= {frame[30:0], sdo};
    nbits <= nbits + 32'h1;
  end
endmodule
`default_nettype wire

//--- dv/tb_isr_readout.sv
`timescale 1ns/1ps
`default_nettype none
module tb_isr_readout;
  import isr_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn;
  logic sck_w = 1'b1;
  logic cs_lift = 1'b0;
  logic sck_out, sck_oe, sck_pullup_en, cs_n, sdi, sdo_out;
  logic [30:0] result_data;
  logic result_valid, result_ready, cfg_valid, internal_mode, converting;
  logic [15:0] cfg_word;
  logic [31:0] frame, nbits;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [30:0] vals [3] = '{31'h5A3C0F81, 31'h2B4D96E6, 31'h7FFF0001};

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Pin level: driver, else pull-up, else a floating low stays low
  always @(sck_oe or sck_out or sck_pullup_en) begin
    if (sck_oe === 1'b1) begin
      sck_w = sck_out;
    end else if (sck_pullup_en === 1'b1) begin
      sck_w = 1'b1;
    end
  end

  isr_readout #(.POR_CYCLES(50), .PROBE_CYCLES(20), .CONV_CYCLES(40)) i_dut (
    .ref_clk(ref_clk), .resetn(resetn), .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe),
    .sck_pullup_en(sck_pullup_en), .cs_n_in(cs_n), .sdi_in(sdi), .sdo_out(sdo_out),
    .result_data(result_data), .result_valid(result_valid), .result_ready(result_ready),
    .cfg_word(cfg_word), .cfg_valid(cfg_valid), .internal_mode(internal_mode), .converting(converting)
  );

  isr_ctrl_model i_ctrl (
    .sck(sck_w), .sdo(sdo_out), .cs_n(cs_n), .sdi(sdi), .cs_lift(cs_lift), .cfg(16'hA5A5), .frame(frame),
    .nbits(nbits)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_sim();
    end
  end

  // Offers all words back to back; the buffer absorbs the stalls
  task automatic push_all();
    int k;
    for (int i = 0; i < 3; i++) begin
      result_data = vals[i];
      result_valid = 1'b1;
      k = 0;
      do begin
        @(posedge ref_clk);
        k++;
      end while (result_ready !== 1'b1 && k < 9000);
      @(negedge ref_clk);
    end
    result_valid = 1'b0;
  endtask

  task automatic run_frame(input logic [30:0] exp);
    logic [31:0] start;
    int k;
    start = nbits;
    k = 0;
    while (converting !== 1'b0 && k < 3000) begin
      @(negedge ref_clk);
      k++;
    end
    check({30'h0, sck_out, sdo_out}, 32'h0);
    repeat (15) @(negedge ref_clk);
    check(nbits, start);
    check({31'h0, sck_pullup_en}, 32'h0);
    k = 0;
    while (nbits !== start + 32'h20 && k < 3000) begin
      @(negedge ref_clk);
      k++;
    end
    check(frame, {1'b0, exp});
    repeat (8) @(negedge ref_clk);
    check({29'h0, sck_out, sdo_out, converting}, 32'h7);
  endtask

  // Chip select lifted in a transfer, probe pulse in sleep, then a second fall leaves internal mode
  task automatic probe_exit();
    logic [31:0] start;
    logic seen;
    int k;
    fork
      push_all();
    join_none
    start = nbits;
    k = 0;
    while (nbits !== start + 32'h1 && k < 3000) begin
      @(negedge ref_clk);
      k++;
    end
    cs_lift = 1'b1;
    k = 0;
    while (nbits !== start + 32'h20 && k < 3000) begin
      @(negedge ref_clk);
      k++;
    end
    check(frame, {1'b0, vals[0]});
    k = 0;
    while (converting !== 1'b0 && k < 3000) begin
      @(negedge ref_clk);
      k++;
    end
    cs_lift = 1'b0;
    repeat (6) @(negedge ref_clk);
    cs_lift = 1'b1;
    seen = 1'b0;
    repeat (8) begin
      @(negedge ref_clk);
      seen = seen | sck_pullup_en;
    end
    check({31'h0, seen}, 32'h1);
    cs_lift = 1'b0;
    repeat (4) @(negedge ref_clk);
    check({30'h0, internal_mode, sck_oe}, 32'h0);
  endtask

  initial begin
    resetn = 1'b0;
    result_valid = 1'b0;
    result_data = '0;
    repeat (16) @(negedge ref_clk);
    check({29'h0, sck_pullup_en, sdo_out, sck_oe}, 32'h6);
    resetn = 1'b1;
    fork
      push_all();
    join_none
    repeat (60) @(negedge ref_clk);
    check({31'h0, internal_mode}, 32'h1);
    run_frame(vals[0]);
    check({16'h0, cfg_word}, 32'hA5A5);
    run_frame(vals[1]);
    run_frame(vals[2]);
    probe_exit();
    end_sim();
  end
endmodule
`default_nettype wire
